// *** tmmd_regs.svh ***
// Offsets, field positions, codes and reset values of the test message decoder
`ifndef TMMD_REGS_SVH
`define TMMD_REGS_SVH
// Summary of operation
// [RULE1] After a multi-slot loop opens, send acknowledgement type 00100011 upstream.
// [RULE2] Recognise type 00001100 from the simulator as link activation command.
// [RULE3] On accepting link activation, reply with message type 00001101.
// [RULE4] Type 00010000 deactivates the test link; no reply is sent.
// [RULE5] Selection message is type 00010100 plus one octet; low three bits.
// [RULE6] Codes 000 none, 001 downlink, 010 uplink, 100 acoustic path tested.
// [RULE7] Other tested-device codes are reserved and give no test function.
// [RULE8] Simulator times loop close to acknowledgement, about 2.5 seconds; the model's limit is SUP_LIMIT, 100 clock cycles.
// [RULE9] The test link is half duplex: one side transmits at a time.
// [RULE10] Simulator exchanges test frames only when a test step needs them.
// [RULE11] Messages with a nonzero skip indicator are discarded without action.
// [RULE12] Each new test function selection replaces the previous one.
// [RULE13] Hold latest selection until replaced or link deactivated; ignore unknowns.

// Register byte offsets
`define TMMD_OFS_CTRL 12'h000
`define TMMD_OFS_STATUS 12'h004
`define TMMD_OFS_COUNT 12'h008
`define TMMD_OFS_LAST 12'h00c

// Control register fields and reset value
`define TMMD_CTRL_EN_BIT 0
`define TMMD_CTRL_CLR_BIT 1
`define TMMD_CTRL_EN_RESET 1'b1

// Status register fields
`define TMMD_STAT_LINK_BIT 0
`define TMMD_STAT_DEV_LSB 1
`define TMMD_STAT_DEV_MSB 3
`define TMMD_STAT_BUSY_BIT 4
`define TMMD_STAT_ACTP_BIT 5
`define TMMD_STAT_LOOPP_BIT 6

// Counter width; counters sit in 8-bit lanes of the count register
`define TMMD_CNT_W 8
`define TMMD_LAST_VALID_BIT 8

// Message type octets
`define TMMD_MT_LOOP_OPEN_ACK 8'h23
`define TMMD_MT_LINK_ACT_CMD 8'h0c
`define TMMD_MT_LINK_ACT_REPLY 8'h0d
`define TMMD_MT_LINK_DEACT_CMD 8'h10
`define TMMD_MT_TEST_IF 8'h14

// Header octet: skip indicator in the upper nibble
`define TMMD_SKIP_MSB 7
`define TMMD_SKIP_LSB 4
`define TMMD_SKIP_OK 4'h0
`define TMMD_PD_DEFAULT 4'hf

// Tested-device field and codes
`define TMMD_DEV_MSB 2
`define TMMD_DEV_LSB 0
`define TMMD_DEV_NONE 3'h0
`define TMMD_DEV_DL 3'h1
`define TMMD_DEV_UL 3'h2
`define TMMD_DEV_ACOUSTIC 3'h4

`endif

// *** tmmd_pkg.sv ***
// Types and shared decode function of the test message decoder
`default_nettype none
`include "tmmd_regs.svh"
package tmmd_pkg;
   // Receive parser position within a message
   typedef enum logic [1:0] {P_HDR, P_TYPE, P_ARG, P_REST} tmmd_pstate_t;
   // Reply transmitter position
   typedef enum logic [1:0] {T_IDLE, T_HDR, T_TYPE} tmmd_tstate_t;

   // True for the four defined tested-device codes
   function automatic logic dev_valid(input logic [2:0] code); // [RULE7]
      return (code == `TMMD_DEV_NONE) || (code == `TMMD_DEV_DL) ||
         (code == `TMMD_DEV_UL) || (code == `TMMD_DEV_ACOUSTIC);
   endfunction : dev_valid
endpackage : tmmd_pkg
`default_nettype wire

// *** tmmd_reply_tx.sv ***
// Two-octet reply sender: header octet then message type octet
`timescale 1ns/1ps
`default_nettype none
`include "tmmd_regs.svh"
module tmmd_reply_tx (
   // Clock, reset, enable
   input wire logic pclk,
   input wire logic presetn,
   input wire logic ce,
   // Reply request
   input wire logic start,
   input wire logic [7:0] msg_type,
   input wire logic [3:0] pd,
   output logic busy,
   // Octet stream toward the link
   output logic tx_valid,
   output logic [7:0] tx_data,
   output logic tx_last,
   input wire logic tx_ready
);
   tmmd_pkg::tmmd_tstate_t tst_reg;
   logic [7:0] data_reg;
   logic [7:0] type_reg;

   assign busy = (tst_reg != tmmd_pkg::T_IDLE);
   assign tx_valid = busy && ce;
   assign tx_data = data_reg;
   assign tx_last = (tst_reg == tmmd_pkg::T_TYPE);

   // Sequencing of header and type octets
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         tst_reg <= tmmd_pkg::T_IDLE;
         data_reg <= 8'h00;
         type_reg <= 8'h00;
      end else if (ce) begin
         unique case (tst_reg)
            tmmd_pkg::T_IDLE: begin
               if (start) begin
                  data_reg <= {`TMMD_SKIP_OK, pd};
                  type_reg <= msg_type;
                  tst_reg <= tmmd_pkg::T_HDR;
               end
            end
            tmmd_pkg::T_HDR: begin
               if (tx_ready) begin
                  data_reg <= type_reg; // [RULE3]
                  tst_reg <= tmmd_pkg::T_TYPE;
               end
            end
            tmmd_pkg::T_TYPE: begin
               if (tx_ready) begin
                  tst_reg <= tmmd_pkg::T_IDLE;
               end
            end
         endcase
      end
   end

   default clocking cb @(posedge pclk); endclocking
   default disable iff (!presetn);

   sequence s_hdr_taken;
      tx_valid && !tx_last && tx_ready;
   endsequence
   sequence s_type_out;
      busy && tx_last && (tx_data == $past(type_reg));
   endsequence

   a_reply_type_follows: // [RULE3]
   assert property (s_hdr_taken |=> s_type_out)
      else $error("reply type octet did not follow header");
   a_reply_header_clean: // [RULE11]
   assert property ((start && !busy && ce) |=> busy && !tx_last &&
      (tx_data[7:4] == `TMMD_SKIP_OK))
      else $error("reply header skip nibble not zero");
endmodule : tmmd_reply_tx
`default_nettype wire

// *** tmmd_decoder.sv ***
// Test message decoder with APB registers and reply generation
//
// The implementer's own choices: the register addresses and the APB interface to the registers.
`timescale 1ns/1ps
`default_nettype none
`include "tmmd_regs.svh"
module tmmd_decoder #(
   parameter logic [3:0] TEST_PD = `TMMD_PD_DEFAULT
) (
   // Clock, reset, enable
   input wire logic pclk,
   input wire logic presetn,
   input wire logic ce,
   // APB slave
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [11:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   // Received message octets from the link
   input wire logic rx_valid,
   input wire logic [7:0] rx_data,
   input wire logic rx_last,
   output logic rx_ready,
   // Reply octets toward the link
   output logic tx_valid,
   output logic [7:0] tx_data,
   output logic tx_last,
   input wire logic tx_ready,
   // Loop event from the test-loop logic
   input wire logic loop_opened,
   // Current test state
   output logic link_active,
   output logic [2:0] tested_device,
   output logic test_dl_decode,
   output logic test_ul_encode,
   output logic test_acoustic
);
   localparam int CW = `TMMD_CNT_W;

   // Address decode shared by read data and error answer
   function automatic logic reg_mapped(input logic [11:0] a);
      return (a == `TMMD_OFS_CTRL) || (a == `TMMD_OFS_STATUS) ||
         (a == `TMMD_OFS_COUNT) || (a == `TMMD_OFS_LAST);
   endfunction : reg_mapped

   // Bus state
   logic acc_reg;
   logic apb_done;
   logic wr_en;
   logic ctrl_wr;
   logic [31:0] rd_data;
   logic en_reg;
   logic cnt_clr;

   // Parser state
   tmmd_pkg::tmmd_pstate_t pst_reg;
   logic skip_bad_reg;
   logic [7:0] type_reg;
   logic [7:0] arg_reg;
   logic rx_fire;
   logic msg_end;
   logic [7:0] mtype;
   logic [7:0] arg_oct;
   logic have_arg;
   logic [2:0] sel_code;

   // Command decode
   logic exec;
   logic discard;
   logic cmd_act;
   logic cmd_deact;
   logic cmd_sel;
   logic sel_ok;
   logic sel_rsv;
   logic cmd_unknown;

   // Test state and replies
   logic link_active_reg;
   logic [2:0] tested_dev_reg;
   logic [7:0] last_type_reg;
   logic last_valid_reg;
   logic act_pend_reg;
   logic loop_pend_reg;
   logic tx_start;
   logic tx_busy;
   logic [7:0] reply_type;

   // Event counters: discarded, unknown type, reserved selection
   logic [2:0] cnt_evt;
   logic [CW-1:0] cnt_reg [3];

   // APB handshake: one wait-free access phase once setup was seen
   assign pready = acc_reg && penable && ce;
   assign apb_done = psel && penable && pready;
   assign wr_en = apb_done && pwrite;
   assign pslverr = apb_done && !reg_mapped(paddr);
   assign ctrl_wr = wr_en && (paddr == `TMMD_OFS_CTRL);
   assign cnt_clr = ctrl_wr && pwdata[`TMMD_CTRL_CLR_BIT];

   // Access phase tracking
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         acc_reg <= 1'b0;
      end else if (ce) begin
         if (apb_done) begin
            acc_reg <= 1'b0;
         end else if (psel && !acc_reg) begin
            acc_reg <= 1'b1;
         end
      end
   end

   // Read data mux
   always_comb begin
      rd_data = 32'h0000_0000;
      unique case (paddr)
         `TMMD_OFS_CTRL: begin
            rd_data[`TMMD_CTRL_EN_BIT] = en_reg;
         end
         `TMMD_OFS_STATUS: begin
            rd_data[`TMMD_STAT_LINK_BIT] = link_active_reg;
            rd_data[`TMMD_STAT_DEV_MSB:`TMMD_STAT_DEV_LSB] = tested_dev_reg;
            rd_data[`TMMD_STAT_BUSY_BIT] = tx_busy;
            rd_data[`TMMD_STAT_ACTP_BIT] = act_pend_reg;
            rd_data[`TMMD_STAT_LOOPP_BIT] = loop_pend_reg;
         end
         `TMMD_OFS_COUNT: begin
            rd_data[CW-1:0] = cnt_reg[0];
            rd_data[CW+7:8] = cnt_reg[1];
            rd_data[CW+15:16] = cnt_reg[2];
         end
         `TMMD_OFS_LAST: begin
            rd_data[7:0] = last_type_reg;
            rd_data[`TMMD_LAST_VALID_BIT] = last_valid_reg;
         end
         default: begin
            rd_data = 32'h0000_0000;
         end
      endcase
   end

   // Read data captured in the setup cycle
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         prdata <= 32'h0000_0000;
      end else if (ce && psel && !acc_reg && !pwrite) begin
         prdata <= reg_mapped(paddr) ? rd_data : 32'h0000_0000;
      end
   end

   // Decoder enable
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         en_reg <= `TMMD_CTRL_EN_RESET;
      end else if (ce && ctrl_wr) begin
         en_reg <= pwdata[`TMMD_CTRL_EN_BIT];
      end
   end

   // Receive is refused while a reply is on the link
   assign tx_start = ce && (act_pend_reg || loop_pend_reg) && !tx_busy &&
      (pst_reg == tmmd_pkg::P_HDR);
   assign rx_ready = ce && !tx_busy && !tx_start; // [RULE9]
   assign rx_fire = rx_valid && rx_ready;

   // Current message fields, taking the octet in flight into account
   assign mtype = (pst_reg == tmmd_pkg::P_TYPE) ? rx_data : type_reg;
   assign arg_oct = (pst_reg == tmmd_pkg::P_ARG) ? rx_data : arg_reg;
   assign have_arg = (pst_reg == tmmd_pkg::P_ARG) ||
      (pst_reg == tmmd_pkg::P_REST);
   assign sel_code = arg_oct[`TMMD_DEV_MSB:`TMMD_DEV_LSB]; // [RULE5]
   assign msg_end = rx_fire && rx_last && (pst_reg != tmmd_pkg::P_HDR);

   // Message parser
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         pst_reg <= tmmd_pkg::P_HDR;
         skip_bad_reg <= 1'b0;
         type_reg <= 8'h00;
         arg_reg <= 8'h00;
      end else if (rx_fire) begin
         unique case (pst_reg)
            tmmd_pkg::P_HDR: begin
               skip_bad_reg <= (rx_data[`TMMD_SKIP_MSB:`TMMD_SKIP_LSB] !=
                  `TMMD_SKIP_OK); // [RULE11]
               if (!rx_last) begin
                  pst_reg <= tmmd_pkg::P_TYPE;
               end
            end
            tmmd_pkg::P_TYPE: begin
               type_reg <= rx_data;
               pst_reg <= rx_last ? tmmd_pkg::P_HDR : tmmd_pkg::P_ARG;
            end
            tmmd_pkg::P_ARG: begin
               arg_reg <= rx_data;
               pst_reg <= rx_last ? tmmd_pkg::P_HDR : tmmd_pkg::P_REST;
            end
            tmmd_pkg::P_REST: begin
               if (rx_last) begin
                  pst_reg <= tmmd_pkg::P_HDR;
               end
            end
         endcase
      end
   end

   // Command decode at the last octet
   assign discard = msg_end && skip_bad_reg; // [RULE11]
   assign exec = msg_end && !skip_bad_reg && en_reg;
   assign cmd_act = exec && (mtype == `TMMD_MT_LINK_ACT_CMD); // [RULE2]
   assign cmd_deact = exec && (mtype == `TMMD_MT_LINK_DEACT_CMD); // [RULE4]
   assign cmd_sel = exec && (mtype == `TMMD_MT_TEST_IF) && have_arg; // [RULE5]
   assign sel_ok = cmd_sel && tmmd_pkg::dev_valid(sel_code); // [RULE7]
   assign sel_rsv = cmd_sel && !tmmd_pkg::dev_valid(sel_code);
   assign cmd_unknown = exec && !cmd_act && !cmd_deact && !cmd_sel; // [RULE13]
   assign cnt_evt = {sel_rsv, cmd_unknown, discard};

   // Link activity state
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         link_active_reg <= 1'b0;
      end else if (cmd_deact) begin
         link_active_reg <= 1'b0; // [RULE4]
      end else if (cmd_act) begin
         link_active_reg <= 1'b1; // [RULE2]
      end
   end

   // Selected tested device
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         tested_dev_reg <= `TMMD_DEV_NONE;
      end else if (cmd_deact) begin
         tested_dev_reg <= `TMMD_DEV_NONE; // [RULE13]
      end else if (sel_ok) begin
         tested_dev_reg <= sel_code; // [RULE12]
      end
   end

   // Last executed message type
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         last_type_reg <= 8'h00;
         last_valid_reg <= 1'b0;
      end else if (exec) begin
         last_type_reg <= mtype;
         last_valid_reg <= 1'b1;
      end
   end

   // Reply requests; a new request beats the clear of the same cycle
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         act_pend_reg <= 1'b0;
      end else if (cmd_act) begin
         act_pend_reg <= 1'b1; // [RULE3]
      end else if (tx_start && act_pend_reg) begin
         act_pend_reg <= 1'b0;
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         loop_pend_reg <= 1'b0;
      end else if (ce && loop_opened) begin
         loop_pend_reg <= 1'b1; // [RULE1]
      end else if (tx_start && !act_pend_reg) begin
         loop_pend_reg <= 1'b0;
      end
   end

   // Activation reply goes first
   assign reply_type = act_pend_reg ? `TMMD_MT_LINK_ACT_REPLY :
      `TMMD_MT_LOOP_OPEN_ACK; // [RULE1] [RULE3]

   // Event counters; an event in the clearing cycle still counts
   genvar g;
   generate
      for (g = 0; g < 3; g++) begin : g_cnt
         always_ff @(posedge pclk or negedge presetn) begin
            if (!presetn) begin
               cnt_reg[g] <= '0;
            end else if (ce && cnt_clr) begin
               cnt_reg[g] <= {{(CW-1){1'b0}}, cnt_evt[g]};
            end else if (cnt_evt[g]) begin
               cnt_reg[g] <= cnt_reg[g] + 1'b1;
            end
         end
      end
   endgenerate

   // Reply sender
   tmmd_reply_tx i_tmmd_reply_tx (
      .pclk(pclk),
      .presetn(presetn),
      .ce(ce),
      .start(tx_start),
      .msg_type(reply_type),
      .pd(TEST_PD),
      .busy(tx_busy),
      .tx_valid(tx_valid),
      .tx_data(tx_data),
      .tx_last(tx_last),
      .tx_ready(tx_ready)
   );

   // Test state outputs; defined codes are one-hot per path
   assign link_active = link_active_reg;
   assign tested_device = tested_dev_reg;
   assign test_dl_decode = (tested_dev_reg == `TMMD_DEV_DL); // [RULE6]
   assign test_ul_encode = (tested_dev_reg == `TMMD_DEV_UL); // [RULE6]
   assign test_acoustic = (tested_dev_reg == `TMMD_DEV_ACOUSTIC); // [RULE6]

   default clocking cb @(posedge pclk); endclocking
   default disable iff (!presetn);

   sequence s_act_seen;
      cmd_act && !cmd_deact;
   endsequence
   sequence s_reply_queued;
      link_active_reg && act_pend_reg;
   endsequence

   a_act_link_up: // [RULE2]
   assert property (s_act_seen |=> s_reply_queued)
      else $error("activation did not raise link and queue reply");
   a_act_reply_type: // [RULE3]
   assert property ((tx_start && act_pend_reg) |->
      (reply_type == 8'h0d) ##1 (tx_busy && !tx_last))
      else $error("activation reply has wrong type");
   a_loop_ack_type: // [RULE1]
   assert property ((tx_start && !act_pend_reg) |->
      (reply_type == 8'h23) && loop_pend_reg)
      else $error("loop open acknowledgement has wrong type");
   a_deact_clears: // [RULE4]
   assert property (cmd_deact |=> !link_active_reg &&
      (tested_dev_reg == 3'h0) && $stable(act_pend_reg))
      else $error("deactivation left link or selection set");
   a_skip_discard: // [RULE11]
   assert property (discard |=> $stable(link_active_reg) &&
      $stable(tested_dev_reg) && $stable(last_type_reg))
      else $error("message with skip indicator was acted on");
   a_reserved_ignored: // [RULE7]
   assert property (sel_rsv |=> $stable(tested_dev_reg))
      else $error("reserved tested-device code changed state");
   a_select_replace: // [RULE12]
   assert property ((sel_ok && !cmd_deact) |=>
      (tested_dev_reg == $past(sel_code)))
      else $error("new selection did not replace old one");
   a_defined_dev_only: // [RULE6]
   assert property (tmmd_pkg::dev_valid(tested_dev_reg) &&
      ((test_dl_decode + test_ul_encode + test_acoustic) <= 2'd1))
      else $error("undefined test function active");
   a_half_duplex: // [RULE9]
   assert property (tx_busy |-> !rx_ready)
      else $error("receive accepted while replying");
   a_unknown_holds: // [RULE13]
   assert property (cmd_unknown |=> $stable(tested_dev_reg) &&
      $stable(link_active_reg))
      else $error("unknown message type changed state");
   a_sel_field_low: // [RULE5]
   assert property (sel_ok |=> (tested_dev_reg == $past(arg_oct[2:0])))
      else $error("selection not taken from low three bits");
endmodule : tmmd_decoder
`default_nettype wire

// *** tmmd_sim_model.sv ***
// Simulator-side model: sends test messages and collects the replies
`timescale 1ns/1ps
`default_nettype none
module tmmd_sim_model #(
   parameter int SUP_LIMIT = 100
) (
   // Clock and reset
   input wire logic pclk,
   input wire logic presetn,
   // Octets toward the decoder
   output logic rx_valid,
   output logic [7:0] rx_data,
   output logic rx_last,
   input wire logic rx_ready,
   // Replies from the decoder
   input wire logic tx_valid,
   input wire logic [7:0] tx_data,
   input wire logic tx_last,
   output logic tx_ready,
   // Stall replies every other cycle
   input wire logic slow,
   // Loop close event that arms the supervision timer
   input wire logic sup_start
);
   logic [8:0] got_q[$];
   logic sup_run = 1'b0;
   logic sup_expired = 1'b0;
   int sup_cnt = 0;

   // Link lines idle at time zero
   initial begin
      rx_valid = 1'b0;
      rx_data = 8'h00;
      rx_last = 1'b0;
   end

   // Sends one message, only when a test step calls it
   task automatic send(input logic [7:0] hdr, input logic [7:0] mt,
      input logic [7:0] arg, input int n);
      logic [7:0] o[3];
      o = '{hdr, mt, arg};
      @(posedge pclk);
      while (tx_valid === 1'b1) @(posedge pclk);
      for (int i = 0; i < n; i++) begin
         rx_valid <= 1'b1;
         rx_data <= o[i];
         rx_last <= (i == n - 1);
         @(posedge pclk);
         while (rx_ready !== 1'b1) @(posedge pclk);
      end
      rx_valid <= 1'b0;
      rx_last <= 1'b0;
      rx_data <= ~o[n - 1]; // Released line shows no stale octet
   endtask : send

   // Collect reply octets with their last flag; stall when asked
   always @(posedge pclk) begin
      if (presetn && tx_valid && tx_ready) got_q.push_back({tx_last, tx_data});
      tx_ready <= (slow && presetn) ? ~tx_ready : 1'b1;
   end

   // Loop supervision: armed at loop close, stopped by the ack
   always @(posedge pclk) begin
      if (tx_valid && tx_ready && tx_data == 8'h23) sup_run <= 1'b0;
      else if (sup_start) sup_run <= 1'b1;
      if (sup_run) sup_cnt <= sup_cnt + 1;
      if (sup_cnt > SUP_LIMIT) sup_expired <= 1'b1;
   end
endmodule : tmmd_sim_model
`default_nettype wire

// *** tmmd_decoder_tb.sv ***
// Self-checking bench for the test message decoder
`timescale 1ns/1ps
`default_nettype none
module tmmd_decoder_tb;
   localparam logic [3:0] PD = 4'h5;
   logic pclk = 1'b0;
   logic presetn = 1'b0;
   logic ce = 1'b1;
   logic psel = 1'b0;
   logic penable = 1'b0;
   logic pwrite = 1'b0;
   logic [11:0] paddr = 12'h000;
   logic [31:0] pwdata = 32'h0;
   logic [31:0] prdata;
   logic pready, pslverr, rx_valid, rx_last, rx_ready;
   logic [7:0] rx_data, tx_data;
   logic tx_valid, tx_last, tx_ready;
   logic loop_opened = 1'b0;
   logic slow = 1'b0;
   logic link_active, test_dl_decode, test_ul_encode, test_acoustic;
   logic [2:0] tested_device;
   int err_count = 0;
   int cmp_count = 0;
   int cyc = 0;

   tmmd_decoder #(.TEST_PD(PD)) i_tmmd_decoder (.pclk(pclk),
      .presetn(presetn), .ce(ce), .psel(psel), .penable(penable),
      .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
      .pready(pready), .pslverr(pslverr), .rx_valid(rx_valid),
      .rx_data(rx_data), .rx_last(rx_last), .rx_ready(rx_ready),
      .tx_valid(tx_valid), .tx_data(tx_data), .tx_last(tx_last),
      .tx_ready(tx_ready), .loop_opened(loop_opened),
      .link_active(link_active), .tested_device(tested_device),
      .test_dl_decode(test_dl_decode), .test_ul_encode(test_ul_encode),
      .test_acoustic(test_acoustic));

   tmmd_sim_model i_tmmd_sim_model (.pclk(pclk), .presetn(presetn),
      .rx_valid(rx_valid), .rx_data(rx_data), .rx_last(rx_last),
      .rx_ready(rx_ready), .tx_valid(tx_valid), .tx_data(tx_data),
      .tx_last(tx_last), .tx_ready(tx_ready), .slow(slow),
      .sup_start(loop_opened));

   // Clock and hang guard
   always #25 pclk = ~pclk;
   always @(posedge pclk) begin
      cyc++;
      if (cyc == 20000) begin
         err_count++;
         end_of_test();
      end
   end

   // Compare and count
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      cmp_count++;
      if (got !== exp) begin
         err_count++;
         $display("mismatch at %0t: got %h expected %h", $time, got, exp);
      end
   endtask : chk

   // One APB transfer, held until pready
   task automatic apb(input logic wr, input logic [11:0] a,
      input logic [31:0] wd, output logic [31:0] rd, output logic err);
      @(posedge pclk);
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= wr;
      paddr <= a;
      pwdata <= wd;
      @(posedge pclk);
      penable <= 1'b1;
      @(posedge pclk);
      while (pready !== 1'b1) @(posedge pclk);
      rd = prdata;
      err = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask : apb

   // Test state outputs against link flag and device code
   task automatic st(input logic l, input logic [2:0] d);
      repeat (2) @(posedge pclk);
      chk({link_active, tested_device, test_acoustic, test_ul_encode,
         test_dl_decode}, {l, d, d == 3'h4, d == 3'h2, d == 3'h1});
   endtask : st

   // Two-octet reply: header then type with last flag
   task automatic reply(input logic [7:0] mt);
      int n;
      n = 0;
      while (i_tmmd_sim_model.got_q.size() < 2 && n < 200) begin
         @(posedge pclk);
         n++;
      end
      repeat (8) @(posedge pclk);
      chk(i_tmmd_sim_model.got_q.size(), 2);
      chk(i_tmmd_sim_model.got_q[0], {1'b0, 4'h0, PD});
      chk(i_tmmd_sim_model.got_q[1], {1'b1, mt});
      i_tmmd_sim_model.got_q.delete();
   endtask : reply

   // Reset state, enable default, unmapped access
   task automatic t_reset();
      logic [31:0] rd;
      logic e;
      st(1'b0, 3'h0);
      apb(1'b0, 12'h000, 32'h0, rd, e);
      chk(rd, 32'h1);
      apb(1'b0, 12'h010, 32'h0, rd, e);
      chk({31'h0, e}, 32'h1);
      chk(rd, 32'h0);
   endtask : t_reset

   // Activation under a stalling sink
   task automatic t_activate();
      slow <= 1'b1;
      i_tmmd_sim_model.send(8'h0f, 8'h0c, 8'h00, 2);
      reply(8'h0d);
      st(1'b1, 3'h0);
      slow <= 1'b0;
   endtask : t_activate

   // Every defined code, each replacing the one before
   task automatic t_select();
      logic [2:0] c[4];
      c = '{3'h1, 3'h2, 3'h4, 3'h0};
      for (int i = 0; i < 4; i++) begin
         i_tmmd_sim_model.send(8'h0f, 8'h14, {5'h00, c[i]}, 3);
         st(1'b1, c[i]);
      end
      i_tmmd_sim_model.send(8'h0f, 8'h14, 8'h02, 3);
      st(1'b1, 3'h2);
   endtask : t_select

   // Reserved codes, skipped, unknown and short messages leave state
   task automatic t_ignored();
      logic [2:0] r[4];
      logic [31:0] rd;
      logic e;
      r = '{3'h3, 3'h5, 3'h6, 3'h7};
      for (int i = 0; i < 4; i++) begin
         i_tmmd_sim_model.send(8'h0f, 8'h14, {5'h00, r[i]}, 3);
         st(1'b1, 3'h2);
      end
      i_tmmd_sim_model.send(8'h1f, 8'h14, 8'h04, 3);
      st(1'b1, 3'h2);
      i_tmmd_sim_model.send(8'hff, 8'h10, 8'h00, 2);
      st(1'b1, 3'h2);
      i_tmmd_sim_model.send(8'h0f, 8'h55, 8'h00, 2);
      st(1'b1, 3'h2);
      i_tmmd_sim_model.send(8'h0f, 8'h14, 8'h00, 2);
      st(1'b1, 3'h2);
      apb(1'b0, 12'h008, 32'h0, rd, e);
      chk(rd, 32'h00040202);
      chk(i_tmmd_sim_model.got_q.size(), 0);
   endtask : t_ignored

   // Loop opening answered with its acknowledgement
   task automatic t_loop();
      @(posedge pclk);
      loop_opened <= 1'b1;
      @(posedge pclk);
      loop_opened <= 1'b0;
      reply(8'h23);
      chk(i_tmmd_sim_model.sup_expired, 1'b0);
   endtask : t_loop

   // Deactivation clears state and sends nothing
   task automatic t_deact();
      i_tmmd_sim_model.send(8'h0f, 8'h10, 8'h00, 2);
      st(1'b0, 3'h0);
      repeat (20) @(posedge pclk);
      chk(i_tmmd_sim_model.got_q.size(), 0);
   endtask : t_deact

   // Enable freeze, register view, counter clear, decoding switched off
   task automatic t_regs();
      logic [31:0] rd;
      logic e;
      ce <= 1'b0;
      repeat (3) @(posedge pclk);
      chk({31'h0, rx_ready}, 32'h0);
      ce <= 1'b1;
      apb(1'b0, 12'h00c, 32'h0, rd, e);
      chk(rd, 32'h0000_0110);
      apb(1'b1, 12'h000, 32'h2, rd, e);
      apb(1'b0, 12'h008, 32'h0, rd, e);
      chk(rd, 32'h0);
      i_tmmd_sim_model.send(8'h0f, 8'h0c, 8'h00, 2);
      st(1'b0, 3'h0);
      apb(1'b0, 12'h004, 32'h0, rd, e);
      chk(rd, 32'h0);
      apb(1'b1, 12'h000, 32'h1, rd, e);
      apb(1'b0, 12'h000, 32'h0, rd, e);
      chk(rd, 32'h1);
   endtask : t_regs

   // Verdict and end of run
   task automatic end_of_test();
      if (err_count == 0 && cmp_count > 0) begin
         $display("All checks passed");
      end else begin
         $display("Checks failed");
      end
      $finish;
   endtask : end_of_test

   // Main sequence
   initial begin
      repeat (6) @(posedge pclk);
      presetn <= 1'b1;
      t_reset();
      t_activate();
      t_select();
      t_ignored();
      t_loop();
      t_deact();
      t_regs();
      end_of_test();
   end
endmodule : tmmd_decoder_tb
`default_nettype wire
